// *** rtl/i2c_regs_pkg.sv ***
/*
 * Shared constants and types of the I2C FIFO and master control register block.
 * Assumes a 32-bit APB register port and a separate free-running link clock.
 */
package i2c_regs_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h20;
   localparam logic [7:0] OFS_TXST = 8'h28;
   localparam logic [7:0] OFS_DATA = 8'h2c;
   localparam logic [7:0] OFS_CTL  = 8'h30;
   localparam logic [7:0] OFS_LOW  = 8'h34;

   // Field positions
   localparam int MODE_PRELOAD_BIT = 0;
   localparam int MODE_MANUAL_BIT  = 1;
   localparam int MODE_LOCK_BIT    = 2;
   localparam int TXST_RDY_BIT     = 0;
   localparam int TXST_LVL_LSB     = 8;
   localparam int CTL_START_BIT    = 0;
   localparam int CTL_RS_BIT       = 1;
   localparam int CTL_STOP_BIT     = 2;
   localparam int CTL_WIDE_BIT     = 7;
   localparam int CTL_MCODE_LSB    = 8;
   localparam int LOW_LSB          = 0;

   // Reset and fixed values
   localparam logic       RDY_RST    = 1'b1;
   localparam logic [8:0] LOW_RST    = 9'h001;
   localparam logic [7:0] EMPTY_READ = 8'hff;
   localparam logic [3:0] FIFO_DEPTH = 4'h8;
   localparam logic [4:0] MCODE_HEAD = 5'h01;

   // Link timing, in link clock cycles
   localparam logic [8:0] SCL_HI_CYC = 9'h004;

   // Link-to-core event toggles
   localparam int EV_RX    = 0;
   localparam int EV_PULL  = 1;
   localparam int EV_RS    = 2;
   localparam int EV_STOP  = 3;
   localparam int EV_DONE  = 4;
   localparam int EV_MATCH = 5;
   localparam int EV_CFG   = 6;
   localparam int EV_N     = 7;

   // Core-to-link signals
   localparam int C_ACK = 0;
   localparam int C_CFG = 1;
   localparam int C_RDY = 2;

   typedef struct packed {
      logic [8:0] scl_down_span;
      logic [2:0] mcode;
      logic       wide;
      logic       start;
      logic       restart;
      logic       stop;
   } link_cfg_t;

   typedef enum logic [2:0] {
      E_IDLE  = 3'b000,
      E_START = 3'b001,
      E_FETCH = 3'b011,
      E_BITS  = 3'b010,
      E_ACK   = 3'b110,
      E_STOP  = 3'b111,
      E_RSTRT = 3'b101
   } eng_t;

endpackage

// *** rtl/i2c_ctl_regs.sv ***
/*
 * I2C FIFO and master control registers with a bit-level master engine.
 * Registers sit on APB (CLOCK_I); the engine and slave-match answer run on LINK_CLK_I.
 * Assumes the slave protocol engine pulses MATCH_I on LINK_CLK_I.
 */
// Chosen here: register access over APB.
`timescale 1ns/10ps
// Overview of operation
// - Status field shows transmit FIFO count, max eight
// - Entering preload mode clears preload ready bit
// - Ready bit low: address match answered NACK
// - Software (manual bit) or a non-empty TX FIFO sets ready; then matches get ACK
// - Preload disabled: ready forced one, resets one
// - Data port read pops RX, write pushes TX
// - Empty RX read returns 0xff, no change
// - Writes to full TX FIFO are dropped
// - Three-bit master code sent before high-speed transfer
// - Width bit selects 7-bit or 10-bit address
// - Stop bit ends transaction; cleared as STOP begins
// - Restart bit gives repeated START; cleared then
// - Start bit begins transfer; cleared when done
// - SCL low lasts at least low count plus one clocks
// - Preload mode: match neither flushes nor locks
// - Manual bit, in preload mode: software, not hardware, drives ready
module i2c_ctl_regs
   import i2c_regs_pkg::*;
(
   // Clock and reset
   input  wire logic        CLOCK_I,
   input  wire logic        RSTN_I,
   input  wire logic        LINK_CLK_I,
   input  wire logic        LINK_RSTN_I,
   // APB slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // I2C pins, open drain
   input  wire logic        SCL_I,
   output logic             SCL_O,
   output logic             SCL_OE_O,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE_O,
   // Slave address match
   input  wire logic        MATCH_I,
   output logic             MATCH_ACK_O
);

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == OFS_MODE) || (a == OFS_TXST) || (a == OFS_DATA) ||
                (a == OFS_CTL) || (a == OFS_LOW);
   endfunction

   // Core domain state
   logic              pready_q;
   logic              pslverr_q;
   logic [31:0]       prdata_q;
   logic              rd_pop_q;
   logic              preload_q;
   logic              manual_q;
   logic              lock_q;
   logic              rdy_q;
   logic              start_q;
   logic              rs_q;
   logic              stop_q;
   logic              wide_q;
   logic [2:0]        mcode_q;
   logic [8:0]        scl_down_span_q;
   logic [7:0]        tx_mem [0:7];
   logic [2:0]        tx_wp_q;
   logic [2:0]        tx_rp_q;
   logic [3:0]        tx_cnt_q;
   logic [7:0]        rx_mem [0:7];
   logic [2:0]        rx_wp_q;
   logic [2:0]        rx_rp_q;
   logic [3:0]        rx_cnt_q;
   logic [7:0]        pull_byte_q;
   logic              pull_empty_q;
   logic              pull_ack_q;
   link_cfg_t         cfg_x_q;
   logic              cfg_req_q;
   logic              cfg_busy_q;
   logic [EV_N-1:0]   ev_s1_q;
   logic [EV_N-1:0]   ev_s2_q;
   logic [EV_N-1:0]   ev_s3_q;
   logic [EV_N-1:0]   ev;
   logic              fire;
   logic              wr_fire;
   logic              rd_fire;
   logic              flush;
   logic              tx_push;
   logic              tx_pop;
   logic              rx_push;
   logic              rx_pop;
   link_cfg_t         cfg_live;

   // Link domain state
   eng_t              st_q;
   link_cfg_t         cfg_l_q;
   logic [2:0]        c_s1_q;
   logic [2:0]        c_s2_q;
   logic [2:0]        c_s3_q;
   logic [1:0]        scl_s_q;
   logic [1:0]        sda_s_q;
   logic              scl_q;
   logic              sda_q;
   logic              phase_q;
   logic [8:0]        cnt_q;
   logic [2:0]        bit_q;
   logic [7:0]        shift_q;
   logic [7:0]        rxb_q;
   logic [1:0]        abytes_q;
   logic              first_q;
   logic              reading_q;
   logic              mc_q;
   logic              pend_q;
   logic              launch_ok_q;
   logic              rs_used_q;
   logic              ack_q;
   logic              tg_rx_q;
   logic              tg_pull_q;
   logic              tg_rs_q;
   logic              tg_stop_q;
   logic              tg_done_q;
   logic              tg_match_q;
   logic              tg_cfg_q;
   logic [EV_N-1:0]   l2c;
   logic              slot_end;
   logic              rx_mode;
   logic              end_rd;

   // ---------------- APB slave, one wait state ----------------
   assign fire     = PSEL_I & PENABLE_I & pready_q;
   assign wr_fire  = fire & PWRITE_I;
   assign rd_fire  = fire & ~PWRITE_I;
   assign PREADY_O = pready_q;
   assign PRDATA_O = prdata_q;
   assign PSLVERR_O = pslverr_q;

   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         rd_pop_q  <= 1'b0;
      end else begin
         pready_q  <= PSEL_I & PENABLE_I & ~pready_q;
         pslverr_q <= PSEL_I & PENABLE_I & ~pready_q & ~reg_hit(PADDR_I);
         rd_pop_q  <= (PADDR_I == OFS_DATA) && (rx_cnt_q != 4'h0);
         prdata_q  <= 32'h0000_0000;
         case (PADDR_I)
            OFS_MODE: prdata_q <= {29'h0, lock_q, manual_q, preload_q};
            OFS_TXST: prdata_q <= {20'h0, tx_cnt_q, 7'h0, rdy_q};
            OFS_DATA: prdata_q <= {24'h0, (rx_cnt_q != 4'h0) ?
                                   rx_mem[rx_rp_q] : EMPTY_READ};
            OFS_CTL:  prdata_q <= {21'h0, mcode_q, wide_q, 4'h0, stop_q, rs_q, start_q};
            OFS_LOW:  prdata_q <= {23'h0, scl_down_span_q};
            default:  prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------- Mode, ready and lockout ----------------
   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
         preload_q <= 1'b0;
         manual_q  <= 1'b0;
         lock_q    <= 1'b0;
      end else begin
         if (wr_fire && PADDR_I == OFS_MODE) begin
            preload_q <= PWDATA_I[MODE_PRELOAD_BIT];
            manual_q  <= PWDATA_I[MODE_MANUAL_BIT];
            if (PWDATA_I[MODE_LOCK_BIT])
               lock_q <= 1'b0;
         end
         if (flush)
            lock_q <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
         rdy_q <= RDY_RST;
      end else if (!preload_q) begin
         if (wr_fire && PADDR_I == OFS_MODE && PWDATA_I[MODE_PRELOAD_BIT])
            rdy_q <= 1'b0;
         else
            rdy_q <= 1'b1;
      end else if (manual_q) begin
         if (wr_fire && PADDR_I == OFS_TXST && PWDATA_I[TXST_RDY_BIT])
            rdy_q <= 1'b1;
      end else if (tx_cnt_q != 4'h0) begin
         rdy_q <= 1'b1;
      end
   end

   // ---------------- Master control and low time ----------------
   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
         start_q <= 1'b0;
         rs_q    <= 1'b0;
         stop_q  <= 1'b0;
         wide_q  <= 1'b0;
         mcode_q <= 3'h0;
         scl_down_span_q <= LOW_RST;
      end else begin
         if (ev[EV_DONE])
            start_q <= 1'b0;
         if (ev[EV_RS])
            rs_q <= 1'b0;
         if (ev[EV_STOP])
            stop_q <= 1'b0;
         if (wr_fire && PADDR_I == OFS_CTL) begin
            mcode_q <= PWDATA_I[CTL_MCODE_LSB +: 3];
            wide_q  <= PWDATA_I[CTL_WIDE_BIT];
            if (PWDATA_I[CTL_START_BIT])
               start_q <= 1'b1;
            if (PWDATA_I[CTL_RS_BIT])
               rs_q <= 1'b1;
            if (PWDATA_I[CTL_STOP_BIT])
               stop_q <= 1'b1;
         end
         if (wr_fire && PADDR_I == OFS_LOW)
            scl_down_span_q <= PWDATA_I[LOW_LSB +: 9];
      end
   end

   // ---------------- Transmit and receive FIFOs ----------------
   assign flush   = ev[EV_MATCH] & ~preload_q;
   assign tx_push = wr_fire && (PADDR_I == OFS_DATA) && (tx_cnt_q != FIFO_DEPTH) &&
                    !lock_q && !flush;
   assign tx_pop  = ev[EV_PULL] && (tx_cnt_q != 4'h0) && !flush;
   assign rx_push = ev[EV_RX] && (rx_cnt_q != FIFO_DEPTH);
   assign rx_pop  = rd_fire && (PADDR_I == OFS_DATA) && rd_pop_q;

   always_ff @(posedge CLOCK_I) begin
      if (tx_push)
         tx_mem[tx_wp_q] <= PWDATA_I[7:0];
      if (rx_push)
         rx_mem[rx_wp_q] <= rxb_q;
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I || flush) begin
         tx_wp_q  <= 3'h0;
         tx_rp_q  <= 3'h0;
         tx_cnt_q <= 4'h0;
      end else begin
         tx_wp_q  <= tx_wp_q + {2'h0, tx_push};
         tx_rp_q  <= tx_rp_q + {2'h0, tx_pop};
         tx_cnt_q <= tx_cnt_q + {3'h0, tx_push} - {3'h0, tx_pop};
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
         rx_wp_q  <= 3'h0;
         rx_rp_q  <= 3'h0;
         rx_cnt_q <= 4'h0;
      end else begin
         rx_wp_q  <= rx_wp_q + {2'h0, rx_push};
         rx_rp_q  <= rx_rp_q + {2'h0, rx_pop};
         rx_cnt_q <= rx_cnt_q + {3'h0, rx_push} - {3'h0, rx_pop};
      end
   end

   // Byte handed to the engine; stays stable until its next request
   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
         pull_byte_q  <= 8'h00;
         pull_empty_q <= 1'b1;
         pull_ack_q   <= 1'b0;
      end else if (ev[EV_PULL]) begin
         pull_byte_q  <= tx_mem[tx_rp_q];
         pull_empty_q <= ~tx_pop;
         pull_ack_q   <= ~pull_ack_q;
      end
   end

   // ---------------- Clock crossings ----------------
   assign cfg_live = '{scl_down_span: scl_down_span_q, mcode: mcode_q, wide: wide_q,
                       start: start_q,
                       restart: rs_q, stop: stop_q};

   // Configuration word is held stable while a handshake is open
   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
         cfg_x_q    <= '{scl_down_span: LOW_RST, default: '0};
         cfg_req_q  <= 1'b0;
         cfg_busy_q <= 1'b0;
      end else if (cfg_busy_q) begin
         if (ev[EV_CFG])
            cfg_busy_q <= 1'b0;
      end else if (cfg_live != cfg_x_q) begin
         cfg_x_q    <= cfg_live;
         cfg_req_q  <= ~cfg_req_q;
         cfg_busy_q <= 1'b1;
      end
   end

   assign l2c = {tg_cfg_q, tg_match_q, tg_done_q, tg_stop_q, tg_rs_q, tg_pull_q, tg_rx_q};
   assign ev  = ev_s2_q ^ ev_s3_q;

   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
         ev_s1_q <= '0;
         ev_s2_q <= '0;
         ev_s3_q <= '0;
      end else begin
         ev_s1_q <= l2c;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
      end
   end

   always_ff @(posedge LINK_CLK_I) begin
      if (!LINK_RSTN_I) begin
         c_s1_q  <= 3'h4;
         c_s2_q  <= 3'h4;
         c_s3_q  <= 3'h4;
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
      end else begin
         c_s1_q  <= {rdy_q, cfg_req_q, pull_ack_q};
         c_s2_q  <= c_s1_q;
         c_s3_q  <= c_s2_q;
         scl_s_q <= {scl_s_q[0], SCL_I};
         sda_s_q <= {sda_s_q[0], SDA_I};
      end
   end

   // ---------------- Link side: config, slave match answer ----------------
   always_ff @(posedge LINK_CLK_I) begin
      if (!LINK_RSTN_I) begin
         cfg_l_q    <= '{scl_down_span: LOW_RST, default: '0};
         tg_cfg_q   <= 1'b0;
         tg_match_q <= 1'b0;
         ack_q      <= RDY_RST;
      end else begin
         if (c_s2_q[C_CFG] ^ c_s3_q[C_CFG]) begin
            cfg_l_q  <= cfg_x_q;
            tg_cfg_q <= ~tg_cfg_q;
         end
         if (MATCH_I)
            tg_match_q <= ~tg_match_q;
         ack_q <= c_s2_q[C_RDY];
      end
   end

   assign MATCH_ACK_O = ack_q;

   // ---------------- Master bit engine ----------------
   assign slot_end = phase_q && scl_s_q[1] && (cnt_q == 9'h000) &&
                     (st_q == E_BITS || st_q == E_ACK || st_q == E_STOP || st_q == E_RSTRT);
   assign rx_mode  = reading_q && (abytes_q == 2'h0) && !mc_q;
   assign end_rd   = cfg_l_q.stop || (cfg_l_q.restart && !rs_used_q);

   always_ff @(posedge LINK_CLK_I) begin
      if (!LINK_RSTN_I) begin
         st_q      <= E_IDLE;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         phase_q   <= 1'b0;
         cnt_q     <= 9'h000;
         bit_q     <= 3'h0;
         shift_q   <= 8'h00;
         rxb_q     <= 8'h00;
         abytes_q  <= 2'h0;
         first_q   <= 1'b0;
         reading_q <= 1'b0;
         mc_q      <= 1'b0;
         pend_q    <= 1'b0;
         launch_ok_q <= 1'b0;
         rs_used_q <= 1'b0;
         tg_rx_q   <= 1'b0;
         tg_pull_q <= 1'b0;
         tg_rs_q   <= 1'b0;
         tg_stop_q <= 1'b0;
         tg_done_q <= 1'b0;
      end else begin
         if (!cfg_l_q.restart)
            rs_used_q <= 1'b0;
         // Shared bit slot: low for count+1 clocks, then high, waiting out stretching
         if (st_q == E_BITS || st_q == E_ACK || st_q == E_STOP || st_q == E_RSTRT) begin
            if (!phase_q) begin
               if (cnt_q == 9'h000) begin
                  phase_q <= 1'b1;
                  scl_q   <= 1'b1;
                  cnt_q   <= SCL_HI_CYC;
               end else begin
                  cnt_q <= cnt_q - 9'h001;
               end
            end else if (scl_s_q[1] && cnt_q != 9'h000) begin
               cnt_q <= cnt_q - 9'h001;
            end
            if (slot_end) begin
               phase_q <= 1'b0;
               cnt_q   <= cfg_l_q.scl_down_span;
            end
         end
         case (st_q)
            E_IDLE: begin
               scl_q <= 1'b1;
               sda_q <= 1'b1;
               if (!cfg_l_q.start) begin
                  launch_ok_q <= 1'b1;
               end else if (launch_ok_q) begin
                  launch_ok_q <= 1'b0;
                  sda_q <= 1'b0;
                  cnt_q <= SCL_HI_CYC;
                  mc_q  <= (cfg_l_q.mcode != 3'h0);
                  st_q  <= E_START;
               end
            end
            E_START: begin
               if (cnt_q != 9'h000) begin
                  cnt_q <= cnt_q - 9'h001;
               end else begin
                  scl_q    <= 1'b0;
                  phase_q  <= 1'b0;
                  cnt_q    <= cfg_l_q.scl_down_span;
                  first_q  <= 1'b1;
                  abytes_q <= cfg_l_q.wide ? 2'h2 : 2'h1;
                  pend_q   <= 1'b0;
                  bit_q    <= 3'h7;
                  if (mc_q) begin
                     shift_q <= {MCODE_HEAD, cfg_l_q.mcode};
                     st_q    <= E_BITS;
                  end else begin
                     st_q <= E_FETCH;
                  end
               end
            end
            E_FETCH: begin
               scl_q <= 1'b0;
               if (!pend_q) begin
                  tg_pull_q <= ~tg_pull_q;
                  pend_q    <= 1'b1;
               end else if (c_s2_q[C_ACK] ^ c_s3_q[C_ACK]) begin
                  pend_q <= 1'b0;
                  if (!pull_empty_q) begin
                     shift_q <= pull_byte_q;
                     bit_q   <= 3'h7;
                     st_q    <= E_BITS;
                     if (first_q) begin
                        reading_q <= pull_byte_q[0];
                        first_q   <= 1'b0;
                     end
                  end else if (cfg_l_q.restart && !rs_used_q) begin
                     rs_used_q <= 1'b1;
                     tg_rs_q   <= ~tg_rs_q;
                     st_q      <= E_RSTRT;
                  end else if (cfg_l_q.stop) begin
                     tg_stop_q <= ~tg_stop_q;
                     st_q      <= E_STOP;
                  end
               end
            end
            E_BITS: begin
               if (!phase_q)
                  sda_q <= rx_mode ? 1'b1 : shift_q[7];
               if (slot_end) begin
                  scl_q   <= 1'b0;
                  shift_q <= {shift_q[6:0], sda_s_q[1]};
                  bit_q   <= bit_q - 3'h1;
                  if (bit_q == 3'h0)
                     st_q <= E_ACK;
               end
            end
            E_ACK: begin
               if (!phase_q)
                  sda_q <= rx_mode ? end_rd : 1'b1;
               if (slot_end) begin
                  scl_q <= 1'b0;
                  bit_q <= 3'h7;
                  if (mc_q) begin
                     mc_q <= 1'b0;
                     st_q <= E_RSTRT;
                  end else if (rx_mode) begin
                     rxb_q   <= shift_q;
                     tg_rx_q <= ~tg_rx_q;
                     if (!end_rd) begin
                        st_q <= E_BITS;
                     end else if (cfg_l_q.restart && !rs_used_q) begin
                        rs_used_q <= 1'b1;
                        tg_rs_q   <= ~tg_rs_q;
                        st_q      <= E_RSTRT;
                     end else begin
                        tg_stop_q <= ~tg_stop_q;
                        st_q      <= E_STOP;
                     end
                  end else if (sda_s_q[1]) begin
                     tg_stop_q <= ~tg_stop_q;
                     st_q      <= E_STOP;
                  end else begin
                     if (abytes_q != 2'h0)
                        abytes_q <= abytes_q - 2'h1;
                     st_q <= (abytes_q == 2'h1 && reading_q) ? E_BITS : E_FETCH;
                  end
               end
            end
            E_STOP: begin
               if (!phase_q)
                  sda_q <= 1'b0;
               if (slot_end) begin
                  sda_q     <= 1'b1;
                  tg_done_q <= ~tg_done_q;
                  st_q      <= E_IDLE;
               end
            end
            E_RSTRT: begin
               if (!phase_q)
                  sda_q <= 1'b1;
               if (slot_end) begin
                  sda_q <= 1'b0;
                  cnt_q <= SCL_HI_CYC;
                  st_q  <= E_START;
               end
            end
            default: st_q <= E_IDLE;
         endcase
      end
   end

   assign SCL_O    = 1'b0;
   assign SDA_O    = 1'b0;
   assign SCL_OE_O = ~scl_q;
   assign SDA_OE_O = ~sda_q;

endmodule // i2c_ctl_regs

// *** bench/i2c_chk_assertions.sv ***
/* Port checker for the I2C register block.
   Assumes the low count is not rewritten during a transfer. */
`timescale 1ns/10ps
module i2c_chk
   import i2c_regs_pkg::*;
(
   input wire logic        CLOCK_I, RSTN_I, PSEL_I, PENABLE_I, PWRITE_I,
   input wire logic        PREADY_O, PSLVERR_O, SCL_OE_O,
   input wire logic [7:0]  PADDR_I,
   input wire logic [31:0] PWDATA_I, PRDATA_O
);
   logic        pre_q;
   logic [8:0]  span_q;
   logic [15:0] cnt_q;
   wire         wr = PREADY_O && PSEL_I && PENABLE_I && PWRITE_I;
   wire         st = PREADY_O && !PWRITE_I && !PSLVERR_O && PADDR_I == OFS_TXST;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RSTN_I);
   always_ff @(posedge CLOCK_I) if (!RSTN_I) pre_q <= 1'h0;
      else if (wr && PADDR_I == OFS_MODE) pre_q <= PWDATA_I[0];
   always_ff @(posedge CLOCK_I) if (!RSTN_I) span_q <= LOW_RST;
      else if (wr && PADDR_I == OFS_LOW) span_q <= PWDATA_I[8:0];
   // Low time in core cycles, 20 per link cycle
   always_ff @(posedge CLOCK_I) cnt_q <= (RSTN_I && SCL_OE_O) ? cnt_q + 16'h1 : 16'h0;
   a_ready_wait: assert property (PSEL_I && !PENABLE_I |=> !PREADY_O ##1 PREADY_O)
      else $error("pready late");
   a_ready_once: assert property (PREADY_O |=> !PREADY_O) else $error("pready held");
   a_err_zero: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
      else $error("bad error read");
   a_lvl_range: assert property (st |-> PRDATA_O[11:8] <= FIFO_DEPTH)
      else $error("level too big");
   a_status_rsvd: assert property (st |-> {PRDATA_O[31:12], PRDATA_O[7:1]} == 27'h0)
      else $error("status reserved");
   a_rdy_forced: assert property (st && !pre_q |-> PRDATA_O[0])
      else $error("ready not forced");
   a_data_rsvd: assert property (PREADY_O && PADDR_I == OFS_DATA |-> !PRDATA_O[31:8])
      else $error("data reserved");
   a_scl_low: assert property ($fell(SCL_OE_O) |-> cnt_q >= 20 * span_q + 19)
      else $error("scl low short");
endmodule // i2c_chk
bind i2c_ctl_regs i2c_chk u_chk (.*);

// *** bench/i2c_bus_model.sv ***
/* Target on the I2C wires: pull-ups, ACK on each byte, clock stretch.
   Assumes enables high while the master pulls low. */
`timescale 1ns/10ps
module i2c_bus_model (
   input  wire logic scl_oe_i,
   input  wire logic sda_oe_i,
   output wire logic scl_o,
   output wire logic sda_o
);
   logic ack_q = 1'h0;
   logic hold_q = 1'h0;
   int   bit_q = 0;
   logic [7:0] sh_q = 8'h00;
   logic [7:0] byte_q = 8'h00;
   int   nbytes = 0;
   // Data bits are taken while SCL is high
   always @(posedge scl_o) if (bit_q >= 1 && bit_q <= 8) sh_q = {sh_q[6:0], sda_o};
   // Released lines rise to the pull-up level
   assign scl_o = !scl_oe_i && !hold_q;
   assign sda_o = !sda_oe_i && !ack_q;
   always @(negedge sda_o) if (scl_o) bit_q = 0;
   always @(negedge scl_o) begin
      if (bit_q == 8) begin
         byte_q = sh_q;
         nbytes++;
      end
      ack_q = (bit_q == 8);
      bit_q = (bit_q == 8) ? 0 : bit_q + 1;
      hold_q = 1'h1;
      #400 hold_q = 1'h0;
   end
endmodule // i2c_bus_model

// *** bench/testbench.sv ***
/* APB register tests and two write transfers.
   Assumes the checker is bound in. */
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t %h/%h", $time, a, e); end end
module testbench;
   import i2c_regs_pkg::*;
   logic        CLOCK_I = '0, RSTN_I = '0, LINK_CLK_I = '0, LINK_RSTN_I = '0;
   logic        PSEL_I = '0, PENABLE_I = '0, PWRITE_I = '0, MATCH_I = '0;
   logic [7:0]  PADDR_I = '0;
   logic [31:0] PWDATA_I = '0, PRDATA_O, rd;
   logic        PREADY_O, PSLVERR_O, SCL_O, SCL_OE_O, SDA_O, SDA_OE_O, MATCH_ACK_O, er;
   wire         SCL_I, SDA_I;
   int          num_errors = 0, checked = 0;
   i2c_ctl_regs u_dut (.*);
   i2c_bus_model u_bus (.scl_oe_i(SCL_OE_O), .sda_oe_i(SDA_OE_O), .scl_o(SCL_I), .sda_o(SDA_I));
   always #2 CLOCK_I = ~CLOCK_I;
   always #40 LINK_CLK_I = ~LINK_CLK_I;
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK_I);
      PSEL_I <= 1'h1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge CLOCK_I);
      PENABLE_I <= 1'h1;
      do @(posedge CLOCK_I); while (PREADY_O !== 1'h1);
      rd = PRDATA_O;
      er = PSLVERR_O;
      PSEL_I <= 1'h0;
      PENABLE_I <= 1'h0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, '0);
      `CHK(rd, e)
   endtask
   task automatic hit;
      @(posedge LINK_CLK_I);
      MATCH_I <= 1'h1;
      @(posedge LINK_CLK_I);
      MATCH_I <= 1'h0;
      repeat (8) @(posedge LINK_CLK_I);
   endtask
   task automatic close_out;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #300000;
      num_errors++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge LINK_CLK_I);
      @(posedge CLOCK_I);
      RSTN_I <= 1'h1;
      LINK_RSTN_I <= 1'h1;
      rchk(OFS_TXST, 32'h1);
      rchk(OFS_DATA, 32'hff);
      rchk(OFS_LOW, 32'h1);
      rchk(8'h00, 32'h0);
      `CHK(er, 1'h1)
      apb(1'h1, OFS_CTL, 32'hfffff7f8);
      rchk(OFS_CTL, 32'h780);
      apb(1'h1, OFS_CTL, 32'h0);
      for (int i = 0; i < 9; i++) apb(1'h1, OFS_DATA, 32'h5a + 32'(i));
      rchk(OFS_TXST, 32'h801);
      apb(1'h1, OFS_LOW, 32'h3);
      apb(1'h1, OFS_CTL, 32'h5);
      apb(1'h1, OFS_CTL, 32'h0);
      rchk(OFS_CTL, 32'h5);
      do apb(1'h0, OFS_CTL, '0); while (rd[0] !== 1'h0);
      `CHK(rd, 32'h0)
      rchk(OFS_TXST, 32'h1);
      `CHK(u_bus.nbytes, 8)
      `CHK(u_bus.byte_q, 8'h61)
      apb(1'h1, OFS_DATA, 32'h44);
      apb(1'h1, OFS_DATA, 32'h33);
      apb(1'h1, OFS_CTL, 32'h107);
      do apb(1'h0, OFS_CTL, '0); while (rd[0] !== 1'h0);
      `CHK(rd, 32'h100)
      `CHK(u_bus.nbytes, 11)
      `CHK(u_bus.byte_q, 8'h33)
      `CHK({SCL_O, SDA_O, SCL_OE_O, SDA_OE_O}, 4'h0)
      apb(1'h1, OFS_MODE, 32'h1);
      rchk(OFS_TXST, 32'h0);
      hit;
      `CHK(MATCH_ACK_O, 1'h0)
      apb(1'h1, OFS_MODE, 32'h3);
      apb(1'h1, OFS_TXST, 32'h1);
      apb(1'h1, OFS_DATA, 32'h3c);
      hit;
      `CHK(MATCH_ACK_O, 1'h1)
      rchk(OFS_TXST, 32'h101);
      apb(1'h1, OFS_MODE, 32'h0);
      hit;
      rchk(OFS_TXST, 32'h1);
      rchk(OFS_MODE, 32'h4);
      apb(1'h1, OFS_DATA, 32'h11);
      rchk(OFS_TXST, 32'h1);
      close_out;
   end
endmodule // testbench
